// >>> logic/lvr_pkg.sv
// Purpose: constants for the low voltage reset and interrupt block
// Assumes: 50 MHz pclk, APB register access
// Notes:   register offsets are byte addresses on the APB
package lvr_pkg;
  localparam logic [11:0] OFS_CONTROL   = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_RESETSRC  = 12'h008;
  localparam int CTL_POWER_ON   = 7;
  localparam int CTL_LEVEL_SEL  = 3;
  localparam int CTL_RESET_EN   = 2;
  localparam int CTL_FALL_EN    = 1;
  localparam int CTL_RISE_EN    = 0;
  localparam int STS_FALL       = 1;
  localparam int STS_RISE       = 0;
  localparam logic [7:0] CTL_RESERVED_ONES = 8'h70;
  localparam logic [7:0] STS_RESERVED_ONES = 8'hFC;
  localparam int unsigned PRESCALE_CYCLES = 131072;
  localparam int PRESCALE_W = 18;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned NOISE_NS = 100;
  // shortest pulse that may reach the reset logic, rounded down
  localparam int unsigned NOISE_CYCLES_RAW = (NOISE_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned NOISE_CYCLES = (NOISE_CYCLES_RAW < 1) ? 1 : NOISE_CYCLES_RAW;
  localparam int NOISE_W = 4;
  typedef enum logic [1:0] {
    LVR_HOLD   = 2'b00,
    LVR_COUNT  = 2'b01,
    LVR_RUN    = 2'b10
  } lvr_phase_e;
endpackage

// >>> logic/lvr_filter.sv
// Purpose: three-stage synchroniser with a glitch filter for one pin
// Assumes: input is asynchronous to pclk
// Notes:   output changes only after a stable level of LEN cycles
`timescale 1ns/10ps
`default_nettype none
module lvr_filter #(
  parameter int          LEN   = 5,
  parameter logic        INIT  = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0]                s;
    logic [lvr_pkg::NOISE_W-1:0] cnt;
    logic                      q;
  } lvr_flt_s;
  lvr_flt_s r;
  lvr_flt_s next_r;
  always_comb begin
    next_r = r;
    next_r.s = {r.s[1:0], din};
    if (r.s[2] != r.s[1] || r.s[1] == r.q) begin
      next_r.cnt = '0;
    end else if (r.cnt == lvr_pkg::NOISE_W'(LEN - 1)) begin
      next_r.q   = r.s[1];
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{s: {3{INIT}}, cnt: '0, q: INIT};
    end else begin
      r <= next_r;
    end
  end
  assign dout = r.q;
endmodule
`default_nettype wire

// >>> logic/lvr_top.sv
// Purpose: low voltage reset, supply fall/rise flags and reset release prescaler
// Assumes: comparators give active-high levels: below the fall and reset thresholds, above the rise threshold
// Notes:   presetn is the power-on reset; watchdog_reset also clears power_on, level_sel and reset_en
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RQ1] status bits 7..2 read one, ignore writes
// [RQ2] fall flag sets when supply below fall
// [RQ3] flags clear by zero write after one read
// [RQ4] rise flag after fall then rise, no reset
// [RQ5] low reset pin holds prescaler and chip
// [RQ6] release internal reset after 131072 cycles
// [RQ7] reset pin passes a 100 ns filter
// [RQ8] reset function idle until software enables
// [RQ9] software powers detector, waits, then enables reset
// [RQ10] software clears reset enable before power
// [RQ11] below reset level drives reset request low
// [RQ12] recovery recounts; control bits survive this reset; code clears fall_en and rise_en
// [RQ13] interrupt function idle until software enables
// [RQ14] software powers detector, waits, enables interrupts
// [RQ15] software clears interrupt enables before power
// [RQ16] fall drives interrupt low, sets flag, irq
// [RQ17] rise drives interrupt high, flag and irq
// [RQ18] software saves data and enters standby
// [RQ19] below lower reset level performs reset
// [RQ20] software clears flags then sets enables
// [RQ21] software clears enables, later detector power
// [RQ22] software sets port outputs after enables
// [RQ23] power-on or watchdog init control, not lvr; watchdog leaves fall_en, rise_en, lvr clears them
// [RQ24] level select chooses low or high threshold
// [RQ25] comparator outputs synchronised before use
// [RQ26] prescaler binary, restarts on any reset; watchdog_reset does not restart it
module lvr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_reset,
  input  wire logic        cmp_below_fall,
  input  wire logic        cmp_above_rise,
  input  wire logic        cmp_below_low_reset,
  input  wire logic        cmp_below_high_reset,
  output logic             detector_power_on,
  output logic             undervoltage_reset_request_n,
  output logic             undervoltage_interrupt_n,
  output logic             external_interrupt_zero,
  output logic             prescaler_overflow,
  output logic             internal_reset_n
);
  typedef struct packed {
    logic [1:0]                      sfall;
    logic [1:0]                      srise;
    logic [1:0]                      slow;
    logic [1:0]                      shigh;
    logic                            power_on;
    logic                            level_sel;
    logic                            reset_en;
    logic                            fall_en;
    logic                            rise_en;
    logic                            fall_flag;
    logic                            rise_flag;
    logic                            fall_seen;
    logic                            rise_seen;
    logic                            armed;
    logic                            prev_fall;
    logic                            prev_rise;
    logic                            lv_reset;
    logic                            lv_cause;
    lvr_pkg::lvr_phase_e             phase;
    logic [lvr_pkg::PRESCALE_W-1:0]  cnt;
    logic                            ovf;
    logic                            int_n;
    logic                            irq;
    logic [31:0]                     rdata;
    logic                            ready;
    logic                            err;
  } lvr_state_s;
  lvr_state_s r;
  lvr_state_s next_r;
  logic pin_n;
  logic wr_access;
  logic rd_access;
  logic below_reset;
  logic fall_ev;
  logic rise_ev;
  logic [7:0] ctl_view;
  logic [7:0] sts_view;
  // [RQ5] [RQ7] filtered reset pin
  lvr_filter #(
    .LEN  (lvr_pkg::NOISE_CYCLES),
    .INIT (1'b0)
  ) u_pin_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (external_reset_pin_n),
    .dout    (pin_n)
  );
  // write lands at the edge where the master sees pready high
  assign wr_access = psel && penable && pwrite && r.ready;
  assign rd_access = psel && penable && !pwrite && !r.ready;
  // [RQ24] threshold choice
  assign below_reset = r.level_sel ? r.shigh[1] : r.slow[1];
  assign fall_ev = r.sfall[1] && !r.prev_fall && r.power_on;
  assign rise_ev = r.srise[1] && !r.prev_rise && r.power_on;
  assign ctl_view = lvr_pkg::CTL_RESERVED_ONES
                  | ({7'h00, r.power_on} << lvr_pkg::CTL_POWER_ON)
                  | ({7'h00, r.level_sel} << lvr_pkg::CTL_LEVEL_SEL)
                  | ({7'h00, r.reset_en} << lvr_pkg::CTL_RESET_EN)
                  | ({7'h00, r.fall_en} << lvr_pkg::CTL_FALL_EN)
                  | ({7'h00, r.rise_en} << lvr_pkg::CTL_RISE_EN);
  // [RQ1] reserved status bits read one
  assign sts_view = lvr_pkg::STS_RESERVED_ONES
                  | ({7'h00, r.fall_flag} << lvr_pkg::STS_FALL)
                  | ({7'h00, r.rise_flag} << lvr_pkg::STS_RISE);
  always_comb begin
    next_r = r;
    // [RQ25] two-stage comparator synchronisers
    next_r.sfall = {r.sfall[0], cmp_below_fall};
    next_r.srise = {r.srise[0], cmp_above_rise};
    next_r.slow  = {r.slow[0], cmp_below_low_reset};
    next_r.shigh = {r.shigh[0], cmp_below_high_reset};
    next_r.prev_fall = r.sfall[1];
    next_r.prev_rise = r.srise[1];
    next_r.irq   = 1'b0;
    next_r.ready = 1'b0;
    next_r.err   = 1'b0;
    if (psel && penable && !r.ready) begin
      next_r.ready = 1'b1;
      if (paddr != lvr_pkg::OFS_CONTROL && paddr != lvr_pkg::OFS_STATUS
          && paddr != lvr_pkg::OFS_RESETSRC) begin
        next_r.err = 1'b1;
      end
    end
    // apb writes; control bits [RQ8] [RQ13] start cleared
    if (wr_access) begin
      if (paddr == lvr_pkg::OFS_CONTROL) begin
        next_r.power_on  = pwdata[lvr_pkg::CTL_POWER_ON];
        next_r.level_sel = pwdata[lvr_pkg::CTL_LEVEL_SEL];
        next_r.reset_en  = pwdata[lvr_pkg::CTL_RESET_EN];
        next_r.fall_en   = pwdata[lvr_pkg::CTL_FALL_EN];
        next_r.rise_en   = pwdata[lvr_pkg::CTL_RISE_EN];
      end else if (paddr == lvr_pkg::OFS_STATUS) begin
        // [RQ3] zero write clears only after a one read
        if (!pwdata[lvr_pkg::STS_FALL] && r.fall_seen) begin
          next_r.fall_flag = 1'b0;
          next_r.fall_seen = 1'b0;
        end
        if (!pwdata[lvr_pkg::STS_RISE] && r.rise_seen) begin
          next_r.rise_flag = 1'b0;
          next_r.rise_seen = 1'b0;
        end
      end
    end
    if (rd_access) begin
      if (paddr == lvr_pkg::OFS_CONTROL) begin
        next_r.rdata = {24'h000000, ctl_view};
      end else if (paddr == lvr_pkg::OFS_STATUS) begin
        next_r.rdata = {24'h000000, sts_view};
        // [RQ3] remember which flags were read as one
        if (r.fall_flag) begin
          next_r.fall_seen = 1'b1;
        end
        if (r.rise_flag) begin
          next_r.rise_seen = 1'b1;
        end
      end else if (paddr == lvr_pkg::OFS_RESETSRC) begin
        next_r.rdata = {30'h00000000, r.lv_cause, r.ovf};
      end else begin
        next_r.rdata = 32'h00000000;
        next_r.err   = 1'b1;
      end
    end
    // [RQ2] [RQ16] supply fall event
    if (fall_ev) begin
      next_r.fall_flag = 1'b1;
      next_r.fall_seen = 1'b0;
      next_r.int_n     = 1'b0;
      next_r.armed     = r.rise_en;
      if (r.fall_en) begin
        next_r.irq = 1'b1;
      end
    end
    // [RQ4] [RQ17] supply rise without dropping to reset level
    if (rise_ev && r.armed && !r.slow[1]) begin
      next_r.int_n = 1'b1;
      next_r.armed = 1'b0;
      if (r.rise_en) begin
        next_r.rise_flag = 1'b1;
        next_r.rise_seen = 1'b0;
        next_r.irq       = 1'b1;
      end
    end
    // [RQ11] [RQ19] low voltage reset entry
    if (r.power_on && r.reset_en && (below_reset || r.slow[1])) begin
      next_r.lv_reset = 1'b1;
      next_r.lv_cause = 1'b1;
    end else begin
      next_r.lv_reset = 1'b0;
    end
    // [RQ5] [RQ6] [RQ12] [RQ26] prescaler phases
    case (r.phase)
      lvr_pkg::LVR_HOLD: begin
        next_r.cnt = '0;
        next_r.ovf = 1'b0;
        if (pin_n && !r.lv_reset) begin
          next_r.phase = lvr_pkg::LVR_COUNT;
        end
      end
      lvr_pkg::LVR_COUNT: begin
        if (r.cnt == lvr_pkg::PRESCALE_W'(lvr_pkg::PRESCALE_CYCLES - 1)) begin
          next_r.ovf   = 1'b1;
          next_r.phase = lvr_pkg::LVR_RUN;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      lvr_pkg::LVR_RUN: begin
        next_r.ovf = 1'b1;
      end
      default: begin
        next_r.phase = lvr_pkg::LVR_HOLD;
      end
    endcase
    if (!pin_n || r.lv_reset) begin
      next_r.phase = lvr_pkg::LVR_HOLD;
      next_r.cnt   = '0;
      next_r.ovf   = 1'b0;
    end
    // [RQ23] pin or watchdog reset clears power_on, level_sel, reset_en; lvr keeps them
    if (!pin_n || watchdog_reset) begin
      next_r.power_on  = 1'b0;
      next_r.level_sel = 1'b0;
      next_r.reset_en  = 1'b0;
      next_r.lv_cause  = 1'b0;
    end
    // flags and interrupt enables cleared by any reset except watchdog_reset
    if (r.phase != lvr_pkg::LVR_RUN) begin
      next_r.fall_en   = 1'b0;
      next_r.rise_en   = 1'b0;
      next_r.fall_flag = 1'b0;
      next_r.rise_flag = 1'b0;
      next_r.fall_seen = 1'b0;
      next_r.rise_seen = 1'b0;
      next_r.armed     = 1'b0;
      next_r.int_n     = 1'b1;
      next_r.irq       = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.int_n <= 1'b1;
      r.phase <= lvr_pkg::LVR_HOLD;
    end else begin
      r <= next_r;
    end
  end
  assign prdata  = r.rdata;
  assign pready  = r.ready;
  assign pslverr = r.err;
  assign detector_power_on            = r.power_on;
  assign undervoltage_reset_request_n = !r.lv_reset;
  assign undervoltage_interrupt_n     = r.int_n;
  assign external_interrupt_zero      = r.irq;
  assign prescaler_overflow           = r.ovf;
  assign internal_reset_n             = r.ovf;

  // [RQ6] overflow only after full count
  a_ovf_after_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.ovf) |-> $past(r.cnt) == lvr_pkg::PRESCALE_W'(lvr_pkg::PRESCALE_CYCLES - 1))
    else $error("overflow without full count");
  // [RQ5] pin low holds reset
  a_pin_holds_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_n |=> !internal_reset_n)
    else $error("pin low did not hold reset");
  // [RQ11] enabled reset below level
  a_lvr_request: assert property (@(posedge pclk) disable iff (!presetn)
    (r.power_on && r.reset_en && (below_reset || r.slow[1]) && pin_n && !watchdog_reset)
    |=> ##1 !internal_reset_n)
    else $error("low voltage reset missing");
  // [RQ1] reserved status bits
  a_sts_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && !r.ready && paddr == lvr_pkg::OFS_STATUS)
    |=> prdata[7:2] == 6'h3F)
    else $error("reserved status bits not one");
  // [RQ3] no clear without a prior one read
  a_flag_no_blind: assert property (@(posedge pclk) disable iff (!presetn)
    (r.fall_flag && !r.fall_seen && !fall_ev && r.phase == lvr_pkg::LVR_RUN)
    |=> r.fall_flag)
    else $error("fall flag cleared without read");
  // [RQ16] fall event raises irq when enabled
  a_fall_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (fall_ev && r.fall_en && r.phase == lvr_pkg::LVR_RUN) |=> external_interrupt_zero && r.fall_flag)
    else $error("fall irq missing");
  // [RQ8] control cleared after pin reset
  a_ctl_standby: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_n |=> !r.reset_en && !r.power_on)
    else $error("control not in standby");
  // [RQ25] flags act only on synchronised input
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.fall_flag) |-> $past(r.sfall[1]))
    else $error("fall flag without synchronised compare");
endmodule
`default_nettype wire

// >>> bench/lvr_supply.sv
// Purpose: supply comparators seen by the low voltage block
// Assumes: supply level given in millivolts by the bench
// Notes:   ideal comparators, no hysteresis
`timescale 1ns/10ps
`default_nettype none
module lvr_supply (
  input  wire logic [15:0] supply_mv,
  output logic             cmp_below_fall,
  output logic             cmp_above_rise,
  output logic             cmp_below_low_reset,
  output logic             cmp_below_high_reset
);
  assign cmp_below_fall = supply_mv < 16'hE74;
  assign cmp_above_rise = supply_mv > 16'hFA0;
  // reset levels 2.3 V and 3.6 V
  assign cmp_below_low_reset = supply_mv < 16'h8FC;
  assign cmp_below_high_reset = supply_mv < 16'hE10;
endmodule
`default_nettype wire

// >>> bench/test_low_voltage_reset_and_interrupt.sv
// Purpose: self-checking bench for the low voltage block
// Assumes: 50 MHz pclk, full 131072 cycle release count
// Notes:   run is about 270k cycles
`timescale 1ns/10ps
`default_nettype none
module test_low_voltage_reset_and_interrupt;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_n = 1'b0;
  logic        wdog = 1'b0;
  logic [15:0] mv = 16'h1388;
  logic        c_fall, c_rise, c_low, c_high;
  logic        pwr_on, rst_req_n, int_n, irq, ovf, irst_n;
  logic [7:0]  m_ctl = 8'h00;
  logic [7:0]  m_sts = 8'h00;
  int          m_irq = 0;
  int          irq_cnt = 0;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] q;
  logic        e;
  lvr_supply sup (.supply_mv(mv), .cmp_below_fall(c_fall), .cmp_above_rise(c_rise),
    .cmp_below_low_reset(c_low), .cmp_below_high_reset(c_high));
  lvr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_n(pin_n), .watchdog_reset(wdog),
    .cmp_below_fall(c_fall), .cmp_above_rise(c_rise), .cmp_below_low_reset(c_low),
    .cmp_below_high_reset(c_high), .detector_power_on(pwr_on),
    .undervoltage_reset_request_n(rst_req_n), .undervoltage_interrupt_n(int_n),
    .external_interrupt_zero(irq), .prescaler_overflow(ovf), .internal_reset_n(irst_n));
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 300000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task final_report();
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check_reg(input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_pin(input logic exp, input logic got);
    check_reg({31'h0, exp}, {31'h0, got});
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    if (a == lvr_pkg::OFS_CONTROL) check_reg({24'h0, m_ctl | 8'h70}, q);
    else check_reg({24'h0, m_sts | 8'hFC}, q);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {$urandom() & 32'hFFFFFF00} | {24'h0, d});
    if (a == lvr_pkg::OFS_CONTROL && irst_n === 1'b1) m_ctl = d & 8'h8F;
  endtask
  task set_mv(input logic [15:0] v, input int n);
    @(posedge pclk);
    mv <= v;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task wait_rel();
    int k;
    k = 0;
    while (irst_n !== 1'b1 && k < 140000) begin
      @(posedge pclk);
      k++;
    end
    check_reg(32'(k >= 131072 && k <= 131090), 32'h1);
  endtask
  initial begin
    $urandom(97577);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    check_pin(1'b0, irst_n);
    pin_n <= 1'b1;
    wait_rel();
    check_pin(1'b1, ovf);
    @(posedge pclk);
    pin_n <= 1'b0;
    repeat (1 + $urandom() % 3) @(posedge pclk);
    pin_n <= 1'b1;
    set_mv(16'h1388, 20);
    check_pin(1'b1, irst_n);
    rd(lvr_pkg::OFS_STATUS);
    wr(lvr_pkg::OFS_STATUS, 8'hFC);
    rd(lvr_pkg::OFS_STATUS);
    rd(lvr_pkg::OFS_CONTROL);
    apb(1'b0, 12'h00C, 32'h0);
    check_reg(32'h0, q);
    check_pin(1'b1, e);
    wr(lvr_pkg::OFS_CONTROL, 8'h80);
    repeat (2500) @(posedge pclk);
    rd(lvr_pkg::OFS_STATUS);
    wr(lvr_pkg::OFS_STATUS, 8'h00);
    wr(lvr_pkg::OFS_CONTROL, 8'h83);
    set_mv(16'hDAC, 10);
    m_sts = 8'h02;
    m_irq = 1;
    check_pin(1'b0, int_n);
    check_reg(32'(m_irq), 32'(irq_cnt));
    wr(lvr_pkg::OFS_STATUS, 8'h00);
    rd(lvr_pkg::OFS_STATUS);
    set_mv(16'h1068, 10);
    m_sts = 8'h03;
    m_irq = 2;
    check_pin(1'b1, int_n);
    check_reg(32'(m_irq), 32'(irq_cnt));
    rd(lvr_pkg::OFS_STATUS);
    wr(lvr_pkg::OFS_STATUS, 8'h00);
    m_sts = 8'h00;
    rd(lvr_pkg::OFS_STATUS);
    wr(lvr_pkg::OFS_CONTROL, 8'h80);
    wr(lvr_pkg::OFS_CONTROL, 8'h84);
    set_mv(16'hBB8, 20);
    check_pin(1'b1, rst_req_n);
    check_pin(1'b1, irst_n);
    wr(lvr_pkg::OFS_CONTROL, 8'h8C);
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    check_pin(1'b0, rst_req_n);
    check_pin(1'b0, irst_n);
    set_mv(16'h1068, 0);
    wait_rel();
    m_sts = 8'h00;
    rd(lvr_pkg::OFS_CONTROL);
    rd(lvr_pkg::OFS_STATUS);
    check_pin(1'b1, pwr_on);
    wr(lvr_pkg::OFS_CONTROL, 8'h88);
    wr(lvr_pkg::OFS_CONTROL, 8'h08);
    rd(lvr_pkg::OFS_CONTROL);
    @(posedge pclk);
    wdog <= 1'b1;
    @(posedge pclk);
    wdog <= 1'b0;
    m_ctl = 8'h00;
    repeat (4) @(posedge pclk);
    rd(lvr_pkg::OFS_CONTROL);
    final_report();
  end
endmodule
`default_nettype wire
